/* File: verilog/iar_pkg.sv */
package iar_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] ADDR_PSW  = 8'h00;
  localparam logic [7:0] ADDR_IMR  = 8'h04;
  localparam logic [7:0] ADDR_AVR  = 8'h08;
  localparam logic [7:0] ADDR_ICR  = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MSK  = 8'h14;
  localparam logic [7:0] ADDR_LAST = 8'h18;

  // Reset values.
  localparam logic [2:0]  PSW_RST = 3'h7;
  localparam logic [6:0]  IMR_RST = 7'h7F;
  localparam logic [7:0]  AVR_RST = 8'h01;
  localparam logic [15:0] ICR_RST = 16'h0000;
  localparam logic [3:0]  MSK_RST = 4'h0;

  // Field positions.
  localparam int AVR_BLK_BIT  = 0;
  localparam int AVR_EN_LSB   = 1;
  localparam int ICR_AUTOVECTOR_ENABLE_BIT = 3;
  localparam int ICR_VEC_LSB  = 8;
  localparam int LAST_VEC_LSB = 8;
  localparam int LAST_ST_LSB  = 4;

  // Sticky event bits of the status register.
  localparam int EV_TAKE = 0;
  localparam int EV_NMI  = 1;
  localparam int EV_ACK  = 2;
  localparam int EV_AUTO = 3;
  localparam int NUM_EV  = 4;

  // Acknowledge cycle encodings.
  localparam logic [1:0]  TT_ACK      = 2'h3;
  localparam logic [26:0] ACK_ADDR_HI = 27'h7FFFFFF;
  localparam logic [1:0]  ACK_ADDR_LO = 2'h0;
  localparam logic [7:0]  AUTOVECTOR_ENABLE_BASE   = 8'h18;
  localparam logic [2:0]  LVL_NMI     = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PEND = 3'b001,
    ST_ADDR = 3'b010,
    ST_WAIT = 3'b011,
    ST_HNDL = 3'b100
  } iar_state_t;

  // External acknowledge bus outputs.
  typedef struct packed {
    logic        address_strobe_n;
    logic        read;
    logic [1:0]  transfer_type;
    logic [2:0]  transfer_modifier;
    logic [31:0] addr;
  } iar_ackbus_t;

  // Interrupt handed to the core.
  typedef struct packed {
    logic       take;
    logic [2:0] level;
    logic [7:0] vector;
  } iar_take_t;

endpackage : iar_pkg

/* File: verilog/iar_ctrl.sv */
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module iar_ctrl (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [2:0]         irq_request_lines_n,
  input  wire logic               transfer_acknowledge_n,
  input  wire logic [7:0]         bus_data_hi,
  input  wire logic               int_src_req,
  input  wire logic               instr_boundary,
  input  wire logic               higher_exc_pending,
  input  wire logic               handler_done,
  output iar_pkg::iar_ackbus_t    ack_bus,
  output iar_pkg::iar_take_t      core_take,
  output logic [2:0]              processor_status_word,
  output logic                    irq
);

  // Synchronisers for pins that come from outside the clock domain.
  logic [2:0] irq_s1_q, irq_s2_q, irq_s3_q;
  logic       ta_s1_q, ta_s2_q, ta_s3_q;
  logic [7:0] dat_s1_q, dat_s2_q, dat_s3_q;

  // Control and register state.
  iar_pkg::iar_state_t  st_q, st_d;
  iar_pkg::iar_ackbus_t bus_q, bus_d;
  iar_pkg::iar_take_t   tk_q, tk_d;
  logic [2:0]  lvl_q, lvl_d, ipl_q, ipl_d, cur_q, cur_d;
  logic [6:0]  imr_q, imr_d;
  logic [7:0]  avr_q, avr_d, vec_q, vec_d;
  logic [15:0] icr_q, icr_d;
  logic [3:0]  stat_q, stat_d, msk_q, msk_d;
  logic [31:0] prdata_q, prdata_d;
  logic        nmi_q, nmi_d, cur_int_q, cur_int_d, pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;

  // Combinational helpers.
  logic        ta_seen, ext7, ext_ok, int_ok, cand, cand_int, acc, wr, rd_done;
  logic [2:0]  cand_lvl, int_lvl;
  logic [3:0]  ev;

  // A level from 1 to 6 passes when not masked in the mask register.
  function automatic logic lvl_unmasked(input logic [2:0] l, input logic [6:0] m);
    logic r;
    r = 1'b0;
    if (l == iar_pkg::LVL_NMI)
      r = 1'b1;
    else if (l != 3'h0)
      r = ~m[l - 3'h1];
    return r;
  endfunction : lvl_unmasked

  // Autovector number for a level.
  function automatic logic [7:0] autovector_enable(input logic [2:0] l);
    return iar_pkg::AUTOVECTOR_ENABLE_BASE + {5'h00, l};
  endfunction : autovector_enable

  // Autovector enable of a level; level 0 has no enable bit and never indexes below the field.
  function automatic logic autovector_enable_en(input logic [2:0] l, input logic [7:0] a);
    return (l != 3'h0) && a[iar_pkg::AVR_EN_LSB + l - 1];
  endfunction : autovector_enable_en

  // Request arbitration between the external pins and the internal source.
  always_comb
  begin
    int_lvl  = icr_q[2:0];
    ta_seen  = (ta_s2_q == ta_s3_q) && !ta_s3_q;
    ext7     = nmi_q || (lvl_q == iar_pkg::LVL_NMI && ipl_q != iar_pkg::LVL_NMI);
    ext_ok   = lvl_unmasked(lvl_q, imr_q) && (lvl_q > ipl_q);
    int_ok   = int_src_req && (int_lvl != 3'h0) && (int_lvl > ipl_q);
    cand     = 1'b0;
    cand_int = 1'b0;
    cand_lvl = 3'h0;
    if (ext7)
    begin
      cand     = 1'b1;
      cand_lvl = iar_pkg::LVL_NMI;
    end
    else if (int_ok && (!ext_ok || int_lvl > lvl_q))
    begin
      cand     = 1'b1;
      cand_int = 1'b1;
      cand_lvl = int_lvl;
    end
    else if (ext_ok && lvl_q != iar_pkg::LVL_NMI)
    begin
      cand     = 1'b1;
      cand_lvl = lvl_q;
    end
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    st_d      = st_q;
    bus_d     = bus_q;
    tk_d      = tk_q;
    tk_d.take = 1'b0;
    lvl_d     = lvl_q;
    nmi_d     = nmi_q;
    ipl_d     = ipl_q;
    imr_d     = imr_q;
    avr_d     = avr_q;
    icr_d     = icr_q;
    msk_d     = msk_q;
    cur_d     = cur_q;
    cur_int_d = cur_int_q;
    vec_d     = vec_q;
    ev        = 4'h0;
    acc       = psel && penable;
    wr        = acc && pready_q && pwrite;
    rd_done   = acc && pready_q && !pwrite;

    // The filtered level moves only once two samples agree.
    if (irq_s2_q == irq_s3_q)
    begin
      lvl_d = ~irq_s3_q;
      if (lvl_d == iar_pkg::LVL_NMI && lvl_q != iar_pkg::LVL_NMI)
      begin
        nmi_d = 1'b1;
        ev[iar_pkg::EV_NMI] = 1'b1;
      end
    end

    // Software writes land first so that hardware updates override them.
    if (wr)
    begin
      if (paddr == iar_pkg::ADDR_PSW)
        ipl_d = pwdata[2:0];
      else if (paddr == iar_pkg::ADDR_IMR)
        imr_d = pwdata[6:0];
      else if (paddr == iar_pkg::ADDR_AVR)
        avr_d = pwdata[7:0];
      else if (paddr == iar_pkg::ADDR_ICR)
        icr_d = pwdata[15:0];
      else if (paddr == iar_pkg::ADDR_MSK)
        msk_d = pwdata[3:0];
    end

    // A handler leaving with level 7 still held puts the mask back to 7.
    if (handler_done && lvl_q == iar_pkg::LVL_NMI && ipl_q < iar_pkg::LVL_NMI)
      ipl_d = iar_pkg::LVL_NMI;

    case (st_q)
      iar_pkg::ST_IDLE:
      begin
        if (cand)
          st_d = iar_pkg::ST_PEND;
      end
      iar_pkg::ST_PEND:
      begin
        // A request dropped before the take is simply forgotten.
        if (!cand)
          st_d = iar_pkg::ST_IDLE;
        else if (instr_boundary && !higher_exc_pending)
        begin
          cur_d     = cand_lvl;
          cur_int_d = cand_int;
          ipl_d     = cand_lvl;
          if (!cand_int && cand_lvl == iar_pkg::LVL_NMI && nmi_d && !ev[iar_pkg::EV_NMI])
            nmi_d = 1'b0;
          // Internal sources and blocked external autovectors take at once, with no bus cycle.
          if (cand_int || (autovector_enable_en(cand_lvl, avr_q) && avr_q[iar_pkg::AVR_BLK_BIT]))
          begin
            ev[iar_pkg::EV_AUTO] = !cand_int || icr_q[iar_pkg::ICR_AUTOVECTOR_ENABLE_BIT];
            vec_d = ev[iar_pkg::EV_AUTO] ? autovector_enable(cand_lvl) : icr_q[iar_pkg::ICR_VEC_LSB +: 8];
            tk_d  = '{take: 1'b1, level: cand_lvl, vector: vec_d};
            ev[iar_pkg::EV_TAKE] = 1'b1;
            st_d  = iar_pkg::ST_HNDL;
          end
          else
          begin
            // Address and qualifiers settle one cycle before the strobe.
            bus_d.read              = 1'b1;
            bus_d.transfer_type     = iar_pkg::TT_ACK;
            bus_d.transfer_modifier = cand_lvl;
            bus_d.addr = {iar_pkg::ACK_ADDR_HI, cand_lvl, iar_pkg::ACK_ADDR_LO};
            st_d = iar_pkg::ST_ADDR;
          end
        end
      end
      iar_pkg::ST_ADDR:
      begin
        bus_d.address_strobe_n = 1'b0;
        st_d = iar_pkg::ST_WAIT;
      end
      iar_pkg::ST_WAIT:
      begin
        // No timeout here: a cycle nobody acknowledges hangs the block.
        if (ta_seen)
        begin
          bus_d.address_strobe_n = 1'b1;
          bus_d.read             = 1'b0;
          bus_d.transfer_type    = 2'h0;
          bus_d.transfer_modifier = 3'h0;
          bus_d.addr             = 32'h0000_0000;
          ev[iar_pkg::EV_AUTO] = autovector_enable_en(cur_q, avr_q);
          vec_d = ev[iar_pkg::EV_AUTO] ? autovector_enable(cur_q) : dat_s3_q;
          tk_d  = '{take: 1'b1, level: cur_q, vector: vec_d};
          ev[iar_pkg::EV_TAKE] = 1'b1;
          ev[iar_pkg::EV_ACK]  = 1'b1;
          st_d  = iar_pkg::ST_HNDL;
        end
      end
      iar_pkg::ST_HNDL:
      begin
        // One handler instruction must retire before the next take.
        if (instr_boundary)
          st_d = iar_pkg::ST_IDLE;
      end
      default:
        st_d = iar_pkg::ST_IDLE;
    endcase

    // Sticky events: a read clears only what it returned, and a new set wins.
    stat_d = stat_q | ev;
    if (rd_done && paddr == iar_pkg::ADDR_STAT)
      stat_d = (stat_q & ~prdata_q[3:0]) | ev;
    irq_d = |(stat_d & msk_d);

    // One wait state: data and ready are prepared in the first access cycle.
    pready_d  = acc && !pready_q;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (acc && !pready_q)
    begin
      prdata_d = 32'h0000_0000;
      if (paddr == iar_pkg::ADDR_PSW)
        prdata_d[2:0] = ipl_q;
      else if (paddr == iar_pkg::ADDR_IMR)
        prdata_d[6:0] = imr_q;
      else if (paddr == iar_pkg::ADDR_AVR)
        prdata_d[7:0] = avr_q;
      else if (paddr == iar_pkg::ADDR_ICR)
        prdata_d[15:0] = icr_q;
      else if (paddr == iar_pkg::ADDR_STAT)
        prdata_d[3:0] = stat_q;
      else if (paddr == iar_pkg::ADDR_MSK)
        prdata_d[3:0] = msk_q;
      else if (paddr == iar_pkg::ADDR_LAST)
        prdata_d = {16'h0000, vec_q, 1'b0, st_q, cur_int_q, cur_q};
      else
        pslverr_d = 1'b1;
    end
  end

  // All state registers; all but the synchronisers reset synchronously.
  always_ff @(posedge clk)
  begin
    irq_s1_q <= irq_request_lines_n;
    irq_s2_q <= irq_s1_q;
    irq_s3_q <= irq_s2_q;
    ta_s1_q  <= transfer_acknowledge_n;
    ta_s2_q  <= ta_s1_q;
    ta_s3_q  <= ta_s2_q;
    dat_s1_q <= bus_data_hi;
    dat_s2_q <= dat_s1_q;
    dat_s3_q <= dat_s2_q;
    if (sys_rst)
    begin
      st_q      <= iar_pkg::ST_IDLE;
      bus_q     <= '{address_strobe_n: 1'b1, default: '0};
      tk_q      <= '0;
      lvl_q     <= 3'h0;
      nmi_q     <= 1'b0;
      ipl_q     <= iar_pkg::PSW_RST;
      imr_q     <= iar_pkg::IMR_RST;
      avr_q     <= iar_pkg::AVR_RST;
      icr_q     <= iar_pkg::ICR_RST;
      stat_q    <= 4'h0;
      msk_q     <= iar_pkg::MSK_RST;
      cur_q     <= 3'h0;
      cur_int_q <= 1'b0;
      vec_q     <= 8'h00;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      bus_q     <= bus_d;
      tk_q      <= tk_d;
      lvl_q     <= lvl_d;
      nmi_q     <= nmi_d;
      ipl_q     <= ipl_d;
      imr_q     <= imr_d;
      avr_q     <= avr_d;
      icr_q     <= icr_d;
      stat_q    <= stat_d;
      msk_q     <= msk_d;
      cur_q     <= cur_d;
      cur_int_q <= cur_int_d;
      vec_q     <= vec_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
    end
  end

  // Outputs come straight from registers.
  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign ack_bus               = bus_q;
  assign core_take             = tk_q;
  assign processor_status_word = ipl_q;
  assign irq                   = irq_q;

endmodule : iar_ctrl

/* File: bench/iar_monitor.sv */
`timescale 1ns/1ps
// Watches the acknowledge cycle and the hand-off to the core.
module iar_monitor (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 transfer_acknowledge_n,
  input wire iar_pkg::iar_ackbus_t ack_bus,
  input wire iar_pkg::iar_take_t   core_take,
  input wire logic [2:0]           processor_status_word
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic stb;
  // A low strobe marks a running acknowledge cycle.
  assign stb = ~ack_bus.address_strobe_n;
  ack_addr_a: assert property (stb |-> ack_bus.addr == {27'h7FFFFFF, ack_bus.transfer_modifier, 2'h0})
    else $error("ack address wrong");
  ack_kind_a: assert property (stb |-> ack_bus.transfer_type == 2'h3 && ack_bus.read)
    else $error("ack not a cpu space read");
  ack_steady_a: assert property (stb && $past(stb) |-> $stable(ack_bus))
    else $error("ack bus moved");
  // The pin is read from the second and third sync stages, so a high pin two edges back forbids ending now.
  ack_wait_a: assert property (stb && $past(transfer_acknowledge_n, 2) |=> stb)
    else $error("cycle ended without acknowledge");
  ack_end_a: assert property ($fell(transfer_acknowledge_n) && stb |-> ##[1:5] !stb)
    else $error("cycle not ended");
  take_end_a: assert property ($rose(ack_bus.address_strobe_n) |-> core_take.take)
    else $error("no take at cycle end");
  take_one_a: assert property (core_take.take |=> !core_take.take)
    else $error("take too long");
  take_mask_a: assert property (core_take.take |-> processor_status_word == core_take.level)
    else $error("mask not set to level");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : iar_monitor

/* File: bench/iar_responder.sv */
`timescale 1ns/1ps
// Interrupting peripheral and vector responder on the far side.
module iar_responder (
  input  wire logic                 clk,
  input  wire logic [2:0]           req_lvl,
  input  wire logic [7:0]           vec,
  input  wire logic [3:0]           dly,
  input  wire iar_pkg::iar_ackbus_t ack_bus,
  output logic [2:0]                irq_request_lines_n,
  output logic                      transfer_acknowledge_n,
  output logic [7:0]                bus_data_hi
);
  logic [3:0] cnt_q = 4'h0;
  // The bench keeps the level until fin clears it after the take.
  assign irq_request_lines_n = ~req_lvl;
  // Idle levels at time zero.
  initial
  begin
    transfer_acknowledge_n = 1'b1;
    bus_data_hi = 8'hA5;
  end
  // Answer after a set wait, holding the vector until the strobe ends; idle data toggles so a stale byte
  // never passes for a vector.
  always @(posedge clk)
  begin
    cnt_q <= ack_bus.address_strobe_n ? 4'h0 : cnt_q + 4'h1;
    if (ack_bus.address_strobe_n)
    begin
      transfer_acknowledge_n <= 1'b1;
      bus_data_hi <= ~bus_data_hi;
    end
    else if (cnt_q >= dly)
    begin
      transfer_acknowledge_n <= 1'b0;
      bus_data_hi <= vec;
    end
  end
endmodule : iar_responder

/* File: bench/tb_interrupt_recognition_iack.sv */
`timescale 1ns/1ps
// Self-checking bench; stimulus changes right after rising edges.
module tb_interrupt_recognition_iack;
  logic                 clk = 1'b0, sys_rst = 1'b1;
  logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00, vec = 8'h00, data_hi;
  logic [31:0]          pwdata = 32'h0, prdata;
  logic                 pready, pslverr, irq, ta_n;
  logic [2:0]           irq_n, psw, req_lvl = 3'h0;
  logic [3:0]           dly = 4'h0;
  logic                 src = 1'b0, bnd = 1'b0, hexc = 1'b0, hdone = 1'b0;
  iar_pkg::iar_ackbus_t ack_bus;
  iar_pkg::iar_take_t   core_take;
  int                   err_total = 0, n_tests = 0;
  iar_ctrl dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_request_lines_n(irq_n),
    .transfer_acknowledge_n(ta_n), .bus_data_hi(data_hi), .int_src_req(src), .instr_boundary(bnd),
    .higher_exc_pending(hexc), .handler_done(hdone), .ack_bus(ack_bus), .core_take(core_take),
    .processor_status_word(psw), .irq(irq));
  iar_responder resp (.clk(clk), .req_lvl(req_lvl), .vec(vec), .dly(dly), .ack_bus(ack_bus),
    .irq_request_lines_n(irq_n), .transfer_acknowledge_n(ta_n), .bus_data_hi(data_hi));
  // Clock, and an instruction boundary every other cycle.
  always #25 clk = ~clk;
  always @(posedge clk) bnd <= ~bnd;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // The slave sets the pace; only the watchdog ends a wait that never finishes.
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    chk(pslverr, a > 8'h18, "apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, x, "read data");
  endtask : rdc
  task automatic take_wait(input int lim, output logic g, output logic s, output iar_pkg::iar_ackbus_t b);
    g = 1'b0;
    s = 1'b0;
    b = '0;
    repeat (lim)
    begin
      @(posedge clk);
      if (ack_bus.address_strobe_n === 1'b0)
      begin
        s = 1'b1;
        b = ack_bus;
      end
      if (core_take.take === 1'b1)
      begin
        g = 1'b1;
        break;
      end
    end
  endtask : take_wait
  task automatic run(input logic [2:0] l, input logic xbus, input logic [7:0] xv);
    logic g, s;
    iar_pkg::iar_ackbus_t b;
    req_lvl <= l;
    take_wait(80, g, s, b);
    chk({g, s, core_take.level, psw, core_take.vector}, {1'b1, xbus, l, l, xv}, "take");
    // Address and kind are compared apart so that every address bit fits the 32-bit compare.
    if (xbus)
    begin
      chk(b.addr, {27'h7FFFFFF, l, 2'h0}, "ack address");
      chk({b.read, b.transfer_type, b.transfer_modifier}, {1'b1, 2'h3, l}, "ack kind");
    end
  endtask : run
  task automatic fin;
    req_lvl <= 3'h0;
    hdone <= 1'b1;
    @(posedge clk);
    hdone <= 1'b0;
    repeat (5) @(posedge clk);
    wr(iar_pkg::ADDR_PSW, 32'h0);
  endtask : fin
  task automatic s_regs;
    rdc(iar_pkg::ADDR_PSW, 32'h7);
    rdc(iar_pkg::ADDR_IMR, 32'h7F);
    rdc(iar_pkg::ADDR_AVR, 32'h1);
    rdc(8'h1C, 32'h0);
    wr(iar_pkg::ADDR_IMR, 32'h0);
    wr(iar_pkg::ADDR_AVR, 32'h0);
    wr(iar_pkg::ADDR_PSW, 32'h0);
  endtask : s_regs
  task automatic s_ext;
    for (int l = 1; l < 7; l++)
    begin
      vec <= 8'h40 + 8'(l);
      dly <= (l % 2) ? 4'h0 : 4'h6;
      run(3'(l), 1'b1, 8'h40 + 8'(l));
      fin();
    end
  endtask : s_ext
  task automatic s_mask;
    logic g, s;
    iar_pkg::iar_ackbus_t b;
    req_lvl <= 3'h6;
    @(posedge clk);
    req_lvl <= 3'h0;
    take_wait(30, g, s, b);
    chk(g, 1'b0, "short request taken");
    wr(iar_pkg::ADDR_PSW, 32'h4);
    req_lvl <= 3'h3;
    take_wait(40, g, s, b);
    chk(g, 1'b0, "level not above mask taken");
    req_lvl <= 3'h0;
    repeat (6) @(posedge clk);
    wr(iar_pkg::ADDR_PSW, 32'h0);
    wr(iar_pkg::ADDR_IMR, 32'h10);
    req_lvl <= 3'h5;
    take_wait(40, g, s, b);
    chk(g, 1'b0, "masked level taken");
    hexc <= 1'b1;
    wr(iar_pkg::ADDR_IMR, 32'h0);
    take_wait(40, g, s, b);
    chk(g, 1'b0, "take over pending exception");
    hexc <= 1'b0;
    vec <= 8'h77;
    run(3'h5, 1'b1, 8'h77);
    fin();
  endtask : s_mask
  task automatic s_auto;
    logic g, s;
    iar_pkg::iar_ackbus_t b;
    wr(iar_pkg::ADDR_AVR, 32'h5);
    vec <= 8'h99;
    run(3'h2, 1'b0, 8'h1A);
    fin();
    wr(iar_pkg::ADDR_AVR, 32'h4);
    run(3'h2, 1'b1, 8'h1A);
    fin();
    wr(iar_pkg::ADDR_ICR, 32'h550C);
    src <= 1'b1;
    take_wait(80, g, s, b);
    chk({g, s, core_take.level, core_take.vector}, {1'b1, 1'b0, 3'h4, iar_pkg::AUTOVECTOR_ENABLE_BASE + 8'h04},
      "internal take");
    src <= 1'b0;
    fin();
    rdc(iar_pkg::ADDR_LAST, {16'h0000, iar_pkg::AUTOVECTOR_ENABLE_BASE + 8'h04, 8'h0C});
    // Without autovector the internal source hands over its own vector.
    wr(iar_pkg::ADDR_ICR, 32'h5504);
    src <= 1'b1;
    take_wait(80, g, s, b);
    chk({g, s, core_take.vector}, {1'b1, 1'b0, 8'h55}, "internal vector");
    src <= 1'b0;
    fin();
  endtask : s_auto
  task automatic s_nmi;
    logic g, s;
    iar_pkg::iar_ackbus_t b;
    wr(iar_pkg::ADDR_AVR, 32'h0);
    wr(iar_pkg::ADDR_PSW, 32'h7);
    vec <= 8'h47;
    run(3'h7, 1'b1, 8'h47);
    take_wait(40, g, s, b);
    chk(g, 1'b0, "held level 7 taken twice");
    req_lvl <= 3'h0;
    repeat (6) @(posedge clk);
    run(3'h7, 1'b1, 8'h47);
    wr(iar_pkg::ADDR_PSW, 32'h3);
    take_wait(40, g, s, b);
    chk({g, psw}, {1'b1, 3'h7}, "no retake");
    // A pending exception blocks the retake, so only the handler end can put the mask back.
    hexc <= 1'b1;
    wr(iar_pkg::ADDR_PSW, 32'h3);
    hdone <= 1'b1;
    @(posedge clk);
    hdone <= 1'b0;
    take_wait(20, g, s, b);
    chk({g, psw}, {1'b0, 3'h7}, "mask not restored");
    hexc <= 1'b0;
    fin();
  endtask : s_nmi
  task automatic s_irq;
    wr(iar_pkg::ADDR_MSK, 32'h0);
    rdc(iar_pkg::ADDR_STAT, 32'hF);
    vec <= 8'h21;
    run(3'h1, 1'b1, 8'h21);
    fin();
    chk(irq, 1'b0, "masked irq");
    wr(iar_pkg::ADDR_MSK, 32'h1);
    chk(irq, 1'b1, "irq low");
    rdc(iar_pkg::ADDR_STAT, 32'h5);
    chk(irq, 1'b0, "irq kept");
  endtask : s_irq
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // Main sequence; status holds the events of every earlier part before the first read.
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    s_regs();
    s_ext();
    s_mask();
    s_auto();
    s_nmi();
    s_irq();
    give_verdict();
  end
  // Cuts a hang short; the whole run needs under two thousand cycles.
  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule : tb_interrupt_recognition_iack
bind iar_ctrl iar_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .pready(pready), .pslverr(pslverr),
  .transfer_acknowledge_n(transfer_acknowledge_n), .ack_bus(ack_bus), .core_take(core_take),
  .processor_status_word(processor_status_word));
